// >>> hdl/flash_protect_pkg.sv
// Package for the flash status word and block-protect logic.
// Shared by the status core and its protect-range decoder.
package flash_protect_pkg;
	localparam int STAT_W = 8;
	localparam int BIT_SWD = 7;
	localparam int BIT_QE = 6;
	localparam int BIT_CODE_HI = 5;
	localparam int BIT_CODE_LO = 2;
	localparam int BIT_WEL = 1;
	localparam int BIT_BUSY = 0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] NV_RESET = 8'h00;
	localparam int ADDR_W = 24;
	localparam int SECTOR_SHIFT = 12;
	localparam int BLOCK_SHIFT = 16;
	localparam logic [23:0] TOP_ADDR_LARGE = 24'h07ffff;
	localparam logic [23:0] TOP_ADDR_SMALL = 24'h03ffff;
	localparam int BLOCKS_LARGE = 8;
	localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECTOR_ERASE_A = 8'h20;
	localparam logic [7:0] OP_SECTOR_ERASE_B = 8'hd7;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
	localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
	localparam logic [7:0] OP_ERASE_ALL_B = 8'hc7;
	localparam logic [7:0] OP_CONFIG_WRITE = 8'h81;
	localparam int BYTE_BITS = 8;
	localparam int STATUS_WRITE_CYCLES = 16;

	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR = 3'b001,
		ST_DATA = 3'b010,
		ST_READ = 3'b011,
		ST_IGNORE = 3'b100
	} frame_state_t;
endpackage

// >>> hdl/protect_range_decode.sv
// Decodes a protect code and density into a protected block mask.
// Pure combinational; the caller checks a target block against it.
`timescale 1ns/100ps
module protect_range_decode
	import flash_protect_pkg::*;
(
	input wire logic [3:0] i_code, // Protect code bits 3..0
	input wire logic i_large, // High for the larger density
	output logic [7:0] o_mask // Protected block per bit
);
	logic [7:0] all_blocks;

	// Small part has blocks 0..3 only; upper bits never match a target
	assign all_blocks = i_large ? 8'hff : 8'h0f;

	always_comb begin
		unique case (i_code)
			4'h0, 4'hf: o_mask = 8'h00;
			4'h1: o_mask = 8'h80;
			4'h2: o_mask = 8'hc0;
			4'h3: o_mask = 8'hf0;
			4'hc: o_mask = 8'h0f;
			4'hd: o_mask = 8'h03;
			4'he: o_mask = 8'h01;
			4'h7, 4'h8: o_mask = all_blocks;
			default: o_mask = all_blocks;
		endcase
	end
endmodule

// >>> hdl/flash_status_protect.sv
// Status word, write-enable latch and block protection of a serial flash.
// Serial pins come from another domain and are synchronised here; the
// array engine is external and reports completion on i_op_done.
`timescale 1ns/100ps
// Contract
// - Array splits into 4 KB sectors, sixteen per 64 KB block.
// - Status: bit7 write-disable, bit6 quad, 5-2 code, 1 latch, 0 busy.
// - Code, write-disable, quad bits nonvolatile, written only by status write.
// - Read-status returns the whole status word.
// - Busy flag read-only, high during program, erase or status write.
// - Latch low refuses every modifying operation.
// - Write-enable instruction sets the latch.
// - Write-disable instruction clears the latch.
// - Latch clears when a modifying operation finishes.
// - Program or erase into a protected region is refused.
// - Whole-array erase only when all code bits are zero.
// - Write-disable set and protect pin low blocks status writes.
// - Write-disable clear or protect pin high allows status writes.
// - Quad bit turns protect and hold pins into data lines.
// - Large part: codes 1,2,3 guard blocks 7, 6-7, 4-7; 0 and f none.
// - Large part: codes c,d,e guard blocks 0-3, 0-1, 0.
// - Large part: codes 7 and 8 guard all blocks.
// - Small part: codes 7 and 8 guard blocks 0 to 3.
// - Modifying frame not a multiple of eight clocks is ignored.
module flash_status_protect
	import flash_protect_pkg::*;
#(
	parameter bit LARGE_DENSITY = 1'b1
) (
	input wire logic i_clk_sys, // System clock, 250 MHz
	input wire logic i_rst_n, // Synchronous reset, active low
	input wire logic i_sck, // Serial clock pin
	input wire logic i_ce_n, // Chip enable pin, active low
	input wire logic i_si, // Serial data in
	input wire logic i_wp_n_io2, // Protect pin in, or data line two in
	input wire logic i_hold_n_io3, // Hold pin in, or data line three in
	input wire logic i_op_done, // Array engine finished current operation
	output logic o_so, // Serial data out
	output logic o_so_oe_n, // Serial out enable, low drives
	output logic o_io2_oe_n, // Data line two enable, low drives
	output logic o_io3_oe_n, // Data line three enable, low drives
	output logic o_quad_enable, // Quad mode selected
	output logic o_hold_n, // Hold request seen when not in quad
	output logic o_op_start, // Pulse: array operation accepted
	output logic [7:0] o_op_code, // Accepted operation code
	output logic [23:0] o_op_addr, // Accepted target address
	output logic [7:0] o_status // Current status word
);
	logic [1:0] sck_s, ce_s, si_s, wp_s, hold_s;
	logic sck_q, ce_q;
	logic [7:0] nv_q, nv_d;
	logic wel_q, wel_d, busy_q, busy_d;
	logic [7:0] shift_q;
	logic [2:0] bitcnt_q;
	logic [5:0] bytecnt_q;
	logic [7:0] opcode_q;
	logic [23:0] addr_q;
	logic [7:0] data_q;
	logic [7:0] so_shift_q;
	logic so_q, so_oe_n_q, start_q;
	logic [7:0] op_code_q;
	logic [23:0] op_addr_q;
	frame_state_t state_q, state_d;
	logic sck_rise, sck_fall, ce_fall, ce_rise;
	logic [7:0] byte_in, protect_mask, status_word;
	logic byte_done, wp_high, status_locked, whole, addr_needed;
	logic is_prog, is_erase, is_whole, is_wstat, modifying;
	logic [2:0] tgt_block;
	logic tgt_protected, tgt_in_range, frame_ok, accept;
	logic is_wstat_run_q;
	logic [4:0] wstat_cnt_q;
	// Shortest legal frames in bytes, opcode included
	localparam logic [5:0] WSTAT_BYTES = 6'h02;
	localparam logic [5:0] PROG_BYTES = 6'h05;
	localparam logic [5:0] ERASE_BYTES = 6'h04;

	function automatic logic needs_addr(input logic [7:0] op);
		needs_addr = op == OP_PAGE_PROG || op == OP_QUAD_PROG ||
			op == OP_SECTOR_ERASE_A || op == OP_SECTOR_ERASE_B ||
			op == OP_BLOCK_ERASE;
	endfunction

	// Pins are asynchronous; logic reads the second stage, plus a third stage of sck and ce for edges
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sck_s <= 2'b00;
			ce_s <= 2'b11;
			si_s <= 2'b00;
			wp_s <= 2'b11;
			hold_s <= 2'b11;
			sck_q <= 1'b0;
			ce_q <= 1'b1;
		end else begin
			sck_s <= {sck_s[0], i_sck};
			ce_s <= {ce_s[0], i_ce_n};
			si_s <= {si_s[0], i_si};
			wp_s <= {wp_s[0], i_wp_n_io2};
			hold_s <= {hold_s[0], i_hold_n_io3};
			sck_q <= sck_s[1];
			ce_q <= ce_s[1];
		end
	end

	assign sck_rise = sck_s[1] && !sck_q && !ce_s[1];
	assign sck_fall = !sck_s[1] && sck_q && !ce_s[1];
	assign ce_fall = !ce_s[1] && ce_q;
	assign ce_rise = ce_s[1] && !ce_q;
	assign byte_in = {shift_q[6:0], si_s[1]};
	assign byte_done = sck_rise && bitcnt_q == 3'd7;

	// Quad mode repurposes the pins, so the protect level reads high
	assign wp_high = nv_q[BIT_QE] || wp_s[1];
	assign status_locked = nv_q[BIT_SWD] && !wp_high;
	assign whole = nv_q[BIT_CODE_HI:BIT_CODE_LO] == 4'h0;
	assign status_word = {nv_q[7:2], wel_q, busy_q};

	protect_range_decode u_decode (
		.i_code(nv_q[BIT_CODE_HI:BIT_CODE_LO]),
		.i_large(LARGE_DENSITY),
		.o_mask(protect_mask)
	);

	// Block is bits above the 64 KB boundary; sectors nest inside it
	assign tgt_block = addr_q[BLOCK_SHIFT +: 3];
	// Targets beyond the top address are refused like guarded ones
	assign tgt_in_range = addr_q <= (LARGE_DENSITY ? TOP_ADDR_LARGE :
		TOP_ADDR_SMALL);
	assign tgt_protected = protect_mask[tgt_block];

	assign is_prog = opcode_q == OP_PAGE_PROG || opcode_q == OP_QUAD_PROG;
	assign is_erase = opcode_q == OP_SECTOR_ERASE_A ||
		opcode_q == OP_SECTOR_ERASE_B || opcode_q == OP_BLOCK_ERASE;
	assign is_whole = opcode_q == OP_ERASE_ALL_A ||
		opcode_q == OP_ERASE_ALL_B;
	assign is_wstat = opcode_q == OP_WRITE_STATUS;
	assign modifying = is_prog || is_erase || is_whole || is_wstat ||
		opcode_q == OP_CONFIG_WRITE;
	assign addr_needed = needs_addr(opcode_q);

	// Frame must end on a byte boundary with enough bytes
	assign frame_ok = bitcnt_q == 3'd0 && state_q != ST_IGNORE &&
		(is_wstat ? bytecnt_q >= WSTAT_BYTES :
		addr_needed ? bytecnt_q >= (is_prog ? PROG_BYTES : ERASE_BYTES) :
		bytecnt_q >= 6'd1);

	always_comb begin
		accept = 1'b0;
		if (ce_rise && frame_ok && modifying && wel_q && !busy_q) begin
			if (is_wstat)
				accept = !status_locked;
			else if (is_whole)
				accept = whole;
			else if (is_prog || is_erase)
				accept = !tgt_protected && tgt_in_range;
		end
	end

	always_comb begin
		nv_d = nv_q;
		wel_d = wel_q;
		busy_d = busy_q;
		if (accept && is_wstat) begin
			// Only the nonvolatile field moves; latch and busy are live
			nv_d = {data_q[7:2], 2'b00};
		end
		if (accept)
			busy_d = 1'b1;
		if (busy_q && (i_op_done || is_wstat_run_q)) begin
			busy_d = 1'b0;
			wel_d = 1'b0;
		end
		// Refused while busy, so a set never meets the completion clear
		if (ce_rise && frame_ok && bytecnt_q == 6'd1 && !busy_q) begin
			if (opcode_q == OP_WRITE_ENABLE)
				wel_d = 1'b1;
			else if (opcode_q == OP_WRITE_DISABLE)
				wel_d = 1'b0;
		end
	end

	always_comb begin
		state_d = state_q;
		if (ce_fall)
			state_d = ST_OPCODE;
		else if (byte_done) begin
			unique case (state_q)
				ST_OPCODE: begin
					if (byte_in == OP_READ_STATUS)
						state_d = ST_READ;
					else if (needs_addr(byte_in))
						state_d = ST_ADDR;
					else
						state_d = ST_DATA;
				end
				ST_ADDR: if (bytecnt_q == 6'd3) state_d = ST_DATA;
				ST_DATA, ST_READ, ST_IGNORE: state_d = state_q;
				default: state_d = ST_IGNORE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q <= ST_IGNORE;
			shift_q <= 8'h00;
			bitcnt_q <= 3'd0;
			bytecnt_q <= 6'd0;
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
			data_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (ce_fall) begin
				bitcnt_q <= 3'd0;
				bytecnt_q <= 6'd0;
				opcode_q <= 8'h00;
			end else if (sck_rise) begin
				shift_q <= byte_in;
				bitcnt_q <= bitcnt_q + 3'd1;
				if (byte_done) begin
					if (bytecnt_q != 6'h3f)
						bytecnt_q <= bytecnt_q + 6'd1;
					if (bytecnt_q == 6'd0)
						opcode_q <= byte_in;
					else if (state_q == ST_ADDR)
						addr_q <= {addr_q[15:0], byte_in};
					else if (bytecnt_q == 6'd1)
						data_q <= byte_in;
				end
			end
		end
	end

	// Status write self-times; array operations wait on the engine
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			nv_q <= NV_RESET;
			wel_q <= STATUS_RESET[BIT_WEL];
			busy_q <= STATUS_RESET[BIT_BUSY];
			is_wstat_run_q <= 1'b0;
			wstat_cnt_q <= 5'd0;
			start_q <= 1'b0;
			op_code_q <= 8'h00;
			op_addr_q <= 24'h000000;
		end else begin
			nv_q <= nv_d;
			wel_q <= wel_d;
			busy_q <= busy_d;
			start_q <= accept && !is_wstat;
			if (accept) begin
				op_code_q <= opcode_q;
				op_addr_q <= addr_q;
			end
			if (accept && is_wstat) begin
				is_wstat_run_q <= 1'b0;
				wstat_cnt_q <= 5'(STATUS_WRITE_CYCLES);
			end else if (wstat_cnt_q != 5'd0) begin
				wstat_cnt_q <= wstat_cnt_q - 5'd1;
				is_wstat_run_q <= wstat_cnt_q == 5'd1;
			end else begin
				is_wstat_run_q <= 1'b0;
			end
		end
	end

	// Read-status streams repeatedly, MSB first, on falling clock
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			so_shift_q <= 8'h00;
			so_q <= 1'b0;
			so_oe_n_q <= 1'b1;
		end else if (ce_s[1]) begin
			so_oe_n_q <= 1'b1;
		end else if (sck_fall && state_q == ST_READ) begin
			if (bitcnt_q == 3'd0) begin
				so_q <= status_word[7];
				so_shift_q <= {status_word[6:0], 1'b0};
			end else begin
				so_q <= so_shift_q[7];
				so_shift_q <= {so_shift_q[6:0], 1'b0};
			end
			so_oe_n_q <= 1'b0;
		end
	end

	assign o_so = so_q;
	assign o_so_oe_n = so_oe_n_q;
	// Quad data phases are outside this block; lines stay released
	assign o_io2_oe_n = 1'b1;
	assign o_io3_oe_n = 1'b1;
	assign o_quad_enable = nv_q[BIT_QE];
	// Hold pauses nothing here; the pad side acts on o_hold_n
	assign o_hold_n = nv_q[BIT_QE] || hold_s[1];
	assign o_op_start = start_q;
	assign o_op_code = op_code_q;
	assign o_op_addr = op_addr_q;
	assign o_status = status_word;
endmodule

// >>> sim/flash_status_properties.sv
// Port assertions for the status and protect block.
// Bound to every instance; sees only the top module's ports.
`timescale 1ns/100ps
module flash_status_props
	import flash_protect_pkg::*;
(
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst_n, // Reset, low
	input wire logic i_ce_n, // Chip enable
	input wire logic i_wp_n_io2, // Protect pin
	input wire logic i_op_done, // Engine done
	input wire logic o_so_oe_n, // Out enable
	input wire logic o_io2_oe_n, // Line two enable
	input wire logic o_io3_oe_n, // Line three enable
	input wire logic o_quad_enable, // Quad bit
	input wire logic o_op_start, // Accept pulse
	input wire logic [7:0] o_op_code, // Accepted op
	input wire logic [7:0] o_status // Status word
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Long enough for the pin to pass the synchroniser
	sequence wp_held;
		(!i_wp_n_io2)[*8];
	endsequence
	sequence erase_all;
		o_op_start && (o_op_code == OP_ERASE_ALL_A ||
			o_op_code == OP_ERASE_ALL_B);
	endsequence
	a_qe_mirror: assert property (
		o_quad_enable == o_status[BIT_QE])
		else $error("quad out differs");
	a_io_released: assert property (
		!o_quad_enable |-> o_io2_oe_n && o_io3_oe_n)
		else $error("line driven outside quad");
	a_start_wel: assert property (
		o_op_start |-> o_status[BIT_WEL])
		else $error("start without latch");
	a_busy_wel: assert property (
		$rose(o_status[BIT_BUSY]) |-> o_status[BIT_WEL])
		else $error("busy without latch");
	a_erase_clear: assert property (
		erase_all |-> o_status[5:2] == 4'h0)
		else $error("whole erase while coded");
	a_done_clear: assert property (
		i_op_done && o_status[BIT_BUSY] |-> ##[1:3] o_status[1:0] == 2'b00)
		else $error("done left busy or latch");
	a_code_hold: assert property (
		!$stable(o_status[7:2]) |-> o_status[BIT_BUSY])
		else $error("protect bits moved idle");
	a_swd_lock: assert property (
		wp_held ##0 (o_status[BIT_SWD] && !o_quad_enable)
		|=> $stable(o_status[7:2]))
		else $error("locked status changed");
	a_so_quiet: assert property (
		i_ce_n [*6] |-> o_so_oe_n)
		else $error("out driven unselected");
endmodule
bind flash_status_protect flash_status_props flash_status_props_i (
	.i_clk_sys, .i_rst_n, .i_ce_n, .i_wp_n_io2, .i_op_done, .o_so_oe_n,
	.o_io2_oe_n, .o_io3_oe_n, .o_quad_enable, .o_op_start, .o_op_code,
	.o_status);

// >>> sim/spi_host_model.sv
// Host model: frames instructions on the flash's serial pins.
// Mode 0; each clock phase lasts four system clocks for the synchroniser.
`timescale 1ns/100ps
module spi_host_model (
	input wire logic i_clk_sys, // System clock
	input wire logic i_so, // Data from device
	output logic o_sck, // Serial clock
	output logic o_ce_n, // Chip enable
	output logic o_si // Data to device
);
	initial begin
		o_sck = 1'b0;
		o_ce_n = 1'b1;
		o_si = 1'b1;
	end
	// Sends n bits of w MSB first; r keeps the last eight bits read
	task automatic frame(input logic [31:0] w, input int n,
		output logic [7:0] r);
		r = 8'h00;
		o_ce_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			o_si = w[31-k];
			repeat (4) @(posedge i_clk_sys);
			#1 o_sck = 1'b1;
			r = {r[6:0], i_so};
			repeat (4) @(posedge i_clk_sys);
			#1 o_sck = 1'b0;
		end
		repeat (4) @(posedge i_clk_sys);
		#1 o_ce_n = 1'b1;
		// Stale data must not look valid between frames
		o_si = ~o_si;
	endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the flash status and protect block.
// Host model frames the pins; the bench plays the array engine.
`timescale 1ns/100ps
module tb_top;
	import flash_protect_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic hold_n = 1'b1;
	logic done = 1'b0;
	logic sck, ce_n, si, so, so_oe_n, qe, hold_out, start, start_s;
	logic [7:0] code, stat, rd;
	logic [23:0] addr;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_start_s = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	flash_status_protect flash_status_protect_i (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_sck(sck), .i_ce_n(ce_n),
		.i_si(si), .i_wp_n_io2(wp_n), .i_hold_n_io3(hold_n),
		.i_op_done(done), .o_so(so), .o_so_oe_n(so_oe_n),
		.o_io2_oe_n(), .o_io3_oe_n(), .o_quad_enable(qe),
		.o_hold_n(hold_out), .o_op_start(start), .o_op_code(code),
		.o_op_addr(addr), .o_status(stat));
	spi_host_model spi_host_model_i (.i_clk_sys(clk), .i_so(so),
		.o_sck(sck), .o_ce_n(ce_n), .o_si(si));
	// Smaller density shares the pins; only its accept pulse is watched
	if (1) begin : g_small
		flash_status_protect #(.LARGE_DENSITY(1'b0)) flash_status_protect_i (
			.i_clk_sys(clk), .i_rst_n(rst_n), .i_sck(sck), .i_ce_n(ce_n),
			.i_si(si), .i_wp_n_io2(wp_n), .i_hold_n_io3(hold_n),
			.i_op_done(done), .o_so(), .o_so_oe_n(), .o_io2_oe_n(),
			.o_io3_oe_n(), .o_quad_enable(), .o_hold_n(),
			.o_op_start(start_s), .o_op_code(), .o_op_addr(),
			.o_status());
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (start === 1'b1) begin
			n_start <= n_start + 1;
		end
		if (start_s === 1'b1) begin
			n_start_s <= n_start_s + 1;
		end
		if (cycles == 70000) begin
			n_mismatch = n_mismatch + 1;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [31:0] w, input int n);
		spi_host_model_i.frame(w, n, rd);
		repeat (8) @(posedge clk);
		#1;
	endtask
	task automatic write_enable_cmd();
		cmd({OP_WRITE_ENABLE, 24'h0}, 8);
	endtask
	task automatic wsr(input logic [7:0] v);
		write_enable_cmd();
		cmd({OP_WRITE_STATUS, v, 16'h0}, 16);
		repeat (20) @(posedge clk);
		#1;
	endtask
	task automatic fin();
		done = 1'b1;
		@(posedge clk) #1 done = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_latch();
		check("reset", stat, STATUS_RESET);
		check("oe", {7'h0, so_oe_n}, 8'h01);
		cmd({OP_WRITE_STATUS, 8'h3c, 16'h0}, 16);
		check("no wel", stat, 8'h00);
		write_enable_cmd();
		check("wel", stat, 8'h02);
		cmd({OP_READ_STATUS, 24'h0}, 16);
		check("read", rd, 8'h02);
		cmd({OP_WRITE_DISABLE, 24'h0}, 8);
		check("write_disable_cmd", stat, 8'h00);
	endtask
	task automatic t_write();
		write_enable_cmd();
		cmd({OP_WRITE_STATUS, 8'h07, 16'h0}, 16);
		check("busy", stat, 8'h07);
		repeat (20) @(posedge clk);
		#1;
		check("stored", stat, 8'h04);
		write_enable_cmd();
		cmd({OP_WRITE_STATUS, 8'h00, 16'h0}, 12);
		check("short", stat, 8'h06);
	endtask
	task automatic t_protect();
		write_enable_cmd();
		cmd({OP_SECTOR_ERASE_A, 24'h070000}, 32);
		check("top", n_start[7:0], 8'h00);
		write_enable_cmd();
		cmd({OP_ERASE_ALL_B, 24'h0}, 8);
		check("whole", n_start[7:0], 8'h00);
		write_enable_cmd();
		cmd({OP_BLOCK_ERASE, 24'h060000}, 32);
		check("start", n_start[7:0], 8'h01);
		check("code", code, OP_BLOCK_ERASE);
		check("addr", addr[23:16], 8'h06);
		check("op busy", stat, 8'h07);
		fin();
		check("done", stat, 8'h04);
		wsr(8'h00);
		write_enable_cmd();
		cmd({OP_ERASE_ALL_A, 24'h0}, 8);
		check("erase", n_start[7:0], 8'h02);
		fin();
	endtask
	task automatic t_lock();
		wsr(8'h80);
		check("swd", stat, 8'h80);
		wp_n = 1'b0;
		wsr(8'h00);
		check("locked", stat, 8'h82);
		wp_n = 1'b1;
		hold_n = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		check("hold", {7'h0, hold_out}, 8'h00);
		wsr(8'h40);
		check("quad", {6'h0, qe, hold_out}, 8'h03);
	endtask
	task automatic t_decode();
		logic [7:0] tab [16];
		logic [7:0] got, got_s;
		int n0, s0;
		tab = '{8'h00, 8'h80, 8'hc0, 8'hf0, 8'hff, 8'hff, 8'hff, 8'hff,
			8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h03, 8'h01, 8'h00};
		// One erase per block; a missing accept pulse marks it guarded
		for (int c = 0; c < 16; c++) begin
			wsr({2'b00, 4'(c), 2'b00});
			for (int b = 0; b < 8; b++) begin
				n0 = n_start;
				s0 = n_start_s;
				write_enable_cmd();
				cmd({OP_BLOCK_ERASE, 5'h00, 3'(b), 16'h0000}, 32);
				got[b] = n_start != n0;
				got_s[b] = n_start_s != s0;
				fin();
			end
			check("mask", ~got, tab[c]);
			// Small part: blocks 4-7 lie beyond its top address
			check("small", ~got_s, tab[c] | 8'hf0);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		t_latch();
		t_write();
		t_protect();
		t_lock();
		t_decode();
		stop_test();
	end
endmodule
